//--- core/rsr_regs.vh
`ifndef RSR_REGS_VH
`define RSR_REGS_VH

// ==========================================================
// register offsets (byte addresses on the 32-bit bus)
`define RSR_OFS_CAUSE 12'h000
`define RSR_OFS_IRQ_STAT 12'h004
`define RSR_OFS_IRQ_MASK 12'h008
`define RSR_OFS_CTRL 12'h00c
`define RSR_OFS_OSC 12'h010
`define RSR_OFS_WDT 12'h014
`define RSR_OFS_STATE 12'h018

// ==========================================================
// reset cause bits
`define RSR_CAUSE_POR 0
`define RSR_CAUSE_EXT 1
`define RSR_CAUSE_BRN 2
`define RSR_CAUSE_WDT 3
`define RSR_CAUSE_SMR 4
`define RSR_CAUSE_W 5

// ==========================================================
// interrupt event bits
`define RSR_EV_EXT 0
`define RSR_EV_INT 1
`define RSR_EV_SMR 2
`define RSR_EV_DBG 3
`define RSR_EV_W 4

// ==========================================================
// control bits
`define RSR_CTRL_IND_EN 0
`define RSR_CTRL_ALT_EN 1
`define RSR_CTRL_RST 8'h02

// ==========================================================
// oscillator control bits
`define RSR_OSC_INT_EN 0
`define RSR_OSC_XTAL_EN 1
`define RSR_OSC_SEL_INT 2
`define RSR_OSC_RST 8'h05
`define RSR_WDT_RST 8'h00

// ==========================================================
// timing counts in system clock cycles
`define RSR_FILT_CYCLES 3
`define RSR_INT_DLY_CYCLES 16
`define RSR_SMR_IPO_CYCLES 66
`define RSR_SMR_XTAL_CYCLES 5000
`define RSR_BLANK_CYCLES 4

// ==========================================================
// reset vector location
`define RSR_VEC_HI_ADDR 16'h0002
`define RSR_VEC_LO_ADDR 16'h0003

`endif

//--- core/rsr_pin_filter.v
`timescale 1ns/1ps
`include "rsr_regs.vh"

module rsr_pin_filter #(
  parameter FILT_CYCLES = `RSR_FILT_CYCLES
) (
  // clock and reset
  input wire clk_sys,
  input wire sys_rst,
  // pin side
  input wire pin_n,
  input wire blank,
  // filtered level
  output reg low_seen
);

  reg sync_a;
  reg sync_b;
  reg [3:0] low_cnt;

  // =========================================================
  // two-stage synchroniser, first stage feeds only the second
  always @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      sync_a <= 1'b1;
      sync_b <= 1'b1;
    end else begin
      sync_a <= pin_n;
      sync_b <= sync_a;
    end
  end

  // =========================================================
  // count consecutive lows; release is immediate so exit is not delayed
  always @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      low_cnt <= 4'h0;
      low_seen <= 1'b0;
    end else if (sync_b || blank) begin
      low_cnt <= 4'h0;
      low_seen <= 1'b0; // leave reset on next edge after release
    end else if (low_cnt >= FILT_CYCLES[3:0] - 4'h1) begin
      low_seen <= 1'b1; // three lows trigger, four always do
    end else begin
      low_cnt <= low_cnt + 4'h1; // two lows or fewer never trigger
    end
  end

endmodule // rsr_pin_filter

//--- core/rsr_hold_counter.v
`timescale 1ns/1ps

module rsr_hold_counter #(
  parameter CW = 16
) (
  // clock and reset
  input wire clk_sys,
  input wire sys_rst,
  // control
  input wire load,
  input wire [CW-1:0] count,
  // status
  output reg busy,
  output reg done
);

  reg [CW-1:0] remain;

  // =========================================================
  // down counter; done pulses once when the hold has elapsed
  always @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      remain <= {CW{1'b0}};
      busy <= 1'b0;
      done <= 1'b0;
    end else begin
      done <= 1'b0;
      if (load) begin
        remain <= count;
        busy <= 1'b1;
      end else if (busy) begin
        if (remain <= {{(CW-1){1'b0}}, 1'b1}) begin
          busy <= 1'b0;
          done <= 1'b1;
        end else begin
          remain <= remain - {{(CW-1){1'b0}}, 1'b1};
        end
      end
    end
  end

endmodule // rsr_hold_counter

//--- core/rsr_top.v
`timescale 1ns/1ps
`include "rsr_regs.vh"

// Summary of operation
// - four filtered low cycles always start reset
// - stay reset while low, exit after release
// - pin reset sets external cause flag
// - pin drives open-drain low in ST_INT; elsewhere in reset only with RSR_CTRL_IND_EN set, never in ST_EXT
// - internal reset drives pin low for delay
// - debugger request resets all but debug unit
// - debugger request bit clears during reset
// - debugger reset sets power-on cause flag
// - stop entered only by stop instruction
// - stop recovery holds cpu 66 or 5000
// - stop recovery touches only watchdog, oscillator
// - stop recovery enables, selects internal oscillator
// - fetch vector from 0002h/0003h, load pc
// - alternate enable gives pin to reset function
module rsr_top #(
  parameter INT_DLY_CYCLES = `RSR_INT_DLY_CYCLES,
  parameter SMR_IPO_CYCLES = `RSR_SMR_IPO_CYCLES,
  parameter SMR_XTAL_CYCLES = `RSR_SMR_XTAL_CYCLES
) (
  // clock and reset
  input wire clk_sys,
  input wire sys_rst,
  // apb slave
  input wire [11:0] paddr,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  // reset pin, open drain
  input wire reset_pin_n_in,
  output reg reset_pin_out,
  output reg reset_pin_oe,
  // gpio use of the pin when the alternate function is off
  input wire gpio_dir_out,
  input wire gpio_out,
  // internal reset sources, one-cycle pulses
  input wire por_event,
  input wire supply_brownout_event,
  input wire watchdog_event,
  // debug unit
  input wire debug_reset_set,
  output reg debug_reset_pending,
  output reg debug_unit_rst,
  // cpu
  input wire stop_instr,
  input wire wake_event,
  output reg cpu_rst,
  output reg periph_rst,
  output reg stop_active,
  output reg [15:0] pm_addr,
  output reg pm_rd,
  input wire [7:0] pm_rdata,
  output reg pc_load,
  output reg [15:0] pc_value,
  // oscillator control
  output reg internal_oscillator_en,
  output reg xtal_en,
  output reg internal_oscillator_sel,
  output reg [7:0] watchdog_control_register,
  // interrupt
  output reg irq
);

  // =========================================================
  // sequencer states
  localparam ST_RUN = 3'h0;
  localparam ST_EXT = 3'h1;
  localparam ST_INT = 3'h2;
  localparam ST_VHI = 3'h3;
  localparam ST_VLO = 3'h4;
  localparam ST_STOP = 3'h5;
  localparam ST_SMR = 3'h6;

  reg [2:0] state;
  reg [`RSR_CAUSE_W-1:0] reset_cause_status_register;
  reg [`RSR_EV_W-1:0] irq_stat;
  reg [`RSR_EV_W-1:0] irq_mask;
  reg [7:0] ctrl;
  reg [7:0] vec_hi;
  reg [`RSR_BLANK_CYCLES-1:0] blank_sr;
  reg int_pend;
  reg dbg_cause;
  reg [15:0] hold_count;
  reg hold_load;
  reg [`RSR_EV_W-1:0] ev;
  reg [`RSR_CAUSE_W-1:0] cause_set;
  reg [31:0] next_rdata;
  reg next_err;
  wire ext_low;
  wire hold_done;
  wire alt_en;
  wire in_sys_reset;
  wire wr_en;
  wire setup;
  wire int_src;

  assign alt_en = ctrl[`RSR_CTRL_ALT_EN];
  assign in_sys_reset = (state == ST_EXT) || (state == ST_INT);
  assign setup = psel && !penable;
  assign wr_en = psel && penable && pready && pwrite;
  assign int_src = por_event || supply_brownout_event || watchdog_event || debug_reset_pending;

  // =========================================================
  // address match helper
  function hit;
    input [11:0] a;
    input [11:0] ofs;
    begin
      hit = (a == ofs);
    end
  endfunction

  // =========================================================
  // pin filter; blanked while and just after we drive the pin ourselves
  rsr_pin_filter #(
    .FILT_CYCLES(`RSR_FILT_CYCLES)
  ) u_filter (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .pin_n(reset_pin_n_in),
    .blank(!alt_en || (|blank_sr)),
    .low_seen(ext_low)
  );

  // =========================================================
  // shared hold counter for internal delay and stop recovery
  rsr_hold_counter #(
    .CW(16)
  ) u_hold (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .load(hold_load),
    .count(hold_count),
    .busy(),
    .done(hold_done)
  );

  // =========================================================
  // sequencer: transitions, hold load requests and event pulses
  always @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      state <= ST_INT;
      hold_load <= 1'b1;
      hold_count <= INT_DLY_CYCLES[15:0];
      int_pend <= 1'b0;
      dbg_cause <= 1'b0;
      ev <= {`RSR_EV_W{1'b0}};
      cause_set <= {`RSR_CAUSE_W{1'b0}};
      cause_set[`RSR_CAUSE_POR] <= 1'b1;
      vec_hi <= 8'h00;
      pc_value <= 16'h0000;
      pc_load <= 1'b0;
      pm_addr <= 16'h0000;
      pm_rd <= 1'b0;
    end else begin
      hold_load <= 1'b0;
      pc_load <= 1'b0;
      pm_rd <= 1'b0;
      ev <= {`RSR_EV_W{1'b0}};
      cause_set <= {`RSR_CAUSE_W{1'b0}};
      if (ext_low && !in_sys_reset) begin
        state <= ST_EXT; // pin low takes precedence everywhere except ST_EXT and ST_INT
      end else if (int_src && !in_sys_reset) begin
        state <= ST_INT; // internal source starts timed reset
        hold_load <= 1'b1;
        hold_count <= INT_DLY_CYCLES[15:0];
        dbg_cause <= debug_reset_pending;
        cause_set[`RSR_CAUSE_POR] <= por_event;
        cause_set[`RSR_CAUSE_BRN] <= supply_brownout_event;
        cause_set[`RSR_CAUSE_WDT] <= watchdog_event;
      end else begin
        case (state)
          ST_EXT: begin
            if (!ext_low) begin
              state <= ST_VHI; // exit on the edge after release
              cause_set[`RSR_CAUSE_EXT] <= 1'b1;
              ev[`RSR_EV_EXT] <= 1'b1;
            end
          end
          ST_INT: begin
            if (hold_done) begin
              state <= ST_VHI;
              ev[`RSR_EV_INT] <= 1'b1;
              if (dbg_cause) begin
                cause_set[`RSR_CAUSE_POR] <= 1'b1;
                ev[`RSR_EV_DBG] <= 1'b1;
              end
              dbg_cause <= 1'b0;
            end
          end
          ST_VHI: begin
            pm_addr <= `RSR_VEC_HI_ADDR;
            pm_rd <= 1'b1;
            state <= ST_VLO;
          end
          ST_VLO: begin
            if (pm_rd && pm_addr == `RSR_VEC_HI_ADDR) begin
              vec_hi <= pm_rdata;
              pm_addr <= `RSR_VEC_LO_ADDR;
              pm_rd <= 1'b1;
            end else begin
              pc_value <= {vec_hi, pm_rdata};
              pc_load <= 1'b1;
              state <= ST_RUN;
            end
          end
          ST_RUN: begin
            if (stop_instr) begin
              state <= ST_STOP; // only the stop instruction enters stop
            end
          end
          ST_STOP: begin
            if (wake_event) begin
              state <= ST_SMR;
              hold_load <= 1'b1;
              if (xtal_en) begin
                hold_count <= SMR_XTAL_CYCLES[15:0];
              end else begin
                hold_count <= SMR_IPO_CYCLES[15:0];
              end
            end
          end
          ST_SMR: begin
            if (hold_done) begin
              state <= ST_VHI;
              cause_set[`RSR_CAUSE_SMR] <= 1'b1;
              ev[`RSR_EV_SMR] <= 1'b1;
            end
          end
          default: begin
            state <= ST_INT;
          end
        endcase
      end
    end
  end

  // =========================================================
  // core and peripheral resets; debug unit only sees the power reset
  always @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      cpu_rst <= 1'b1;
      periph_rst <= 1'b1;
      stop_active <= 1'b0;
      debug_unit_rst <= 1'b1;
    end else begin
      debug_unit_rst <= 1'b0; // debugger state survives its own reset
      periph_rst <= in_sys_reset || (ext_low && !in_sys_reset) || int_src;
      cpu_rst <= (state != ST_RUN) && (state != ST_STOP); // held during recovery
      stop_active <= (state == ST_STOP);
    end
  end

  // =========================================================
  // debugger request bit; cleared by the reset it causes
  always @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      debug_reset_pending <= 1'b0;
    end else if (debug_reset_set) begin
      debug_reset_pending <= 1'b1; // a fresh request beats the clear
    end else if (state == ST_INT) begin
      debug_reset_pending <= 1'b0;
    end
  end

  // =========================================================
  // pin driver; the reset function owns the pin only with alt enabled
  always @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      reset_pin_out <= 1'b0;
      reset_pin_oe <= 1'b1;
      blank_sr <= {`RSR_BLANK_CYCLES{1'b1}};
    end else begin
      if (alt_en) begin
        reset_pin_out <= 1'b0; // open drain: only ever pulls low
        // not in ST_EXT, where our own low would mask the release
        reset_pin_oe <= (state == ST_INT) || (ctrl[`RSR_CTRL_IND_EN] && cpu_rst && state != ST_EXT);
      end else begin
        reset_pin_out <= gpio_out; // plain port i/o under its direction
        reset_pin_oe <= gpio_dir_out;
      end
      // our own low must not echo back as an external reset
      blank_sr <= {blank_sr[`RSR_BLANK_CYCLES-2:0], reset_pin_oe && (state != ST_EXT)};
    end
  end

  // =========================================================
  // cause register survives system reset; cleared only by power reset or by writing ones
  always @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      reset_cause_status_register <= {`RSR_CAUSE_W{1'b0}};
    end else begin
      reset_cause_status_register <= cause_set |
        (reset_cause_status_register &
        ~((wr_en && hit(paddr, `RSR_OFS_CAUSE)) ? pwdata[`RSR_CAUSE_W-1:0] :
        {`RSR_CAUSE_W{1'b0}}));
    end
  end

  // =========================================================
  // interrupt status, write one to clear, set wins over clear
  always @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      irq_stat <= {`RSR_EV_W{1'b0}};
      irq_mask <= {`RSR_EV_W{1'b0}};
      irq <= 1'b0;
    end else begin
      irq_stat <= ev | (irq_stat &
        ~((wr_en && hit(paddr, `RSR_OFS_IRQ_STAT)) ? pwdata[`RSR_EV_W-1:0] :
        {`RSR_EV_W{1'b0}}));
      if (wr_en && hit(paddr, `RSR_OFS_IRQ_MASK)) begin
        irq_mask <= pwdata[`RSR_EV_W-1:0];
      end
      irq <= |((irq_stat | ev) & irq_mask);
    end
  end

  // =========================================================
  // control, oscillator and watchdog control registers
  always @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      ctrl <= `RSR_CTRL_RST;
      internal_oscillator_en <= 1'b1;
      xtal_en <= 1'b0;
      internal_oscillator_sel <= 1'b1;
      watchdog_control_register <= `RSR_WDT_RST;
    end else if (periph_rst) begin
      // system reset restores these; debug state is elsewhere
      ctrl <= `RSR_CTRL_RST;
      internal_oscillator_en <= 1'b1;
      xtal_en <= 1'b0;
      internal_oscillator_sel <= 1'b1;
      watchdog_control_register <= `RSR_WDT_RST;
    end else if (state == ST_SMR && hold_done) begin
      // only these two registers change on stop recovery
      internal_oscillator_en <= 1'b1;
      internal_oscillator_sel <= 1'b1;
      watchdog_control_register <= `RSR_WDT_RST;
    end else if (wr_en) begin
      if (hit(paddr, `RSR_OFS_CTRL)) begin
        ctrl <= pwdata[7:0];
      end else if (hit(paddr, `RSR_OFS_OSC)) begin
        internal_oscillator_en <= pwdata[`RSR_OSC_INT_EN];
        xtal_en <= pwdata[`RSR_OSC_XTAL_EN];
        internal_oscillator_sel <= pwdata[`RSR_OSC_SEL_INT];
      end else if (hit(paddr, `RSR_OFS_WDT)) begin
        watchdog_control_register <= pwdata[7:0];
      end
    end
  end

  // =========================================================
  // read mux, sampled in the setup cycle
  always @* begin
    next_rdata = 32'h0000_0000;
    next_err = 1'b0;
    if (hit(paddr, `RSR_OFS_CAUSE)) begin
      next_rdata[`RSR_CAUSE_W-1:0] = reset_cause_status_register;
    end else if (hit(paddr, `RSR_OFS_IRQ_STAT)) begin
      next_rdata[`RSR_EV_W-1:0] = irq_stat;
    end else if (hit(paddr, `RSR_OFS_IRQ_MASK)) begin
      next_rdata[`RSR_EV_W-1:0] = irq_mask;
    end else if (hit(paddr, `RSR_OFS_CTRL)) begin
      next_rdata[7:0] = ctrl;
    end else if (hit(paddr, `RSR_OFS_OSC)) begin
      next_rdata[2:0] = {internal_oscillator_sel, xtal_en, internal_oscillator_en};
    end else if (hit(paddr, `RSR_OFS_WDT)) begin
      next_rdata[7:0] = watchdog_control_register;
    end else if (hit(paddr, `RSR_OFS_STATE)) begin
      next_rdata = {pc_value, 11'h000, debug_reset_pending, ext_low, state};
    end else begin
      next_err = 1'b1;
    end
  end

  // =========================================================
  // apb answer: one wait-free access phase after setup
  always @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= 1'b1;
      if (setup) begin
        prdata <= pwrite ? 32'h0000_0000 : next_rdata;
        pslverr <= next_err;
      end
    end
  end

endmodule // rsr_top

//--- verification/rsr_pin_partner.sv
`timescale 1ns/1ps

// ==========
// other parts on the open-drain reset line, with its pull-up
module rsr_pin_partner (
  // clock
  input wire clk_sys,
  // device side of the pin
  input wire reset_pin_out,
  input wire reset_pin_oe,
  // resolved line level
  output wire pin_level
);
  reg pull_n = 1'b1;

  // wired-and with pull-up
  assign pin_level = pull_n & (reset_pin_oe ? reset_pin_out : 1'b1);

  // pull low for n cycles, from just after an edge
  task automatic pull_low(input int n);
    @(posedge clk_sys);
    pull_n <= 1'b0;
    repeat (n) @(posedge clk_sys);
    pull_n <= 1'b1;
  endtask
endmodule // rsr_pin_partner

//--- verification/rsr_top_props.sv
`timescale 1ns/1ps

// ==========
// reset sequencing checks on the top-level ports
module rsr_top_props #(
  parameter SMR_IPO_CYCLES = 66,
  parameter SMR_XTAL_CYCLES = 5000
) (
  // clock and reset
  input wire clk_sys,
  input wire sys_rst,
  // pin
  input wire reset_pin_n_in,
  input wire reset_pin_out,
  input wire reset_pin_oe,
  // reset sources and debug unit
  input wire por_event,
  input wire supply_brownout_event,
  input wire watchdog_event,
  input wire debug_reset_pending,
  input wire debug_unit_rst,
  // cpu
  input wire stop_instr,
  input wire wake_event,
  input wire cpu_rst,
  input wire periph_rst,
  input wire stop_active,
  input wire [15:0] pm_addr,
  input wire pm_rd,
  input wire pc_load,
  // oscillator and watchdog
  input wire internal_oscillator_en,
  input wire internal_oscillator_sel,
  input wire xtal_en,
  input wire [7:0] watchdog_control_register
);
  reg smr_seen;
  reg smr_xtal;
  reg [15:0] hold;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);

  // stop recovery cycle count, vector fetch included
  always @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      smr_seen <= 1'b0;
      smr_xtal <= 1'b0;
      hold <= 16'h0000;
    end else if (stop_active && wake_event) begin
      smr_seen <= 1'b1;
      smr_xtal <= xtal_en;
      hold <= 16'h0000;
    end else if (smr_seen && $fell(cpu_rst)) begin
      smr_seen <= 1'b0;
    end else if (smr_seen && cpu_rst) begin
      hold <= hold + 16'h0001;
    end
  end

  long_low_a: assert property (
    (!reset_pin_n_in && !reset_pin_oe) [*4] |-> ##[0:4] cpu_rst)
    else $error("long low ignored");
  glitch_ignore_a: assert property (
    (!cpu_rst && !stop_active && !reset_pin_oe && $fell(reset_pin_n_in)) ##[1:2]
    $rose(reset_pin_n_in) |-> !cpu_rst [*6])
    else $error("glitch caused reset");
  stay_reset_a: assert property (!reset_pin_n_in && cpu_rst |=> cpu_rst)
    else $error("reset left while pin low");
  exit_bound_a: assert property ($rose(reset_pin_n_in) && cpu_rst |-> ##[1:12] !cpu_rst)
    else $error("no exit after release");
  internal_drive_a: assert property (
    (por_event || supply_brownout_event || watchdog_event) && !cpu_rst
    |-> ##[1:3] (reset_pin_oe && !reset_pin_out) [*8])
    else $error("pin not driven low");
  debug_keep_a: assert property (
    $rose(debug_reset_pending) |-> ##[0:4] (periph_rst && !debug_unit_rst))
    else $error("debug reset wrong scope");
  debug_clear_a: assert property (
    $rose(debug_reset_pending) |-> ##[1:20] (!debug_reset_pending && periph_rst))
    else $error("debug request kept");
  stop_entry_a: assert property ($rose(stop_active) |-> $past(stop_instr, 2))
    else $error("stop without instruction");
  smr_hold_a: assert property (smr_seen && $fell(cpu_rst) |->
    hold >= (smr_xtal ? SMR_XTAL_CYCLES : SMR_IPO_CYCLES) &&
    hold <= (smr_xtal ? SMR_XTAL_CYCLES : SMR_IPO_CYCLES) + 12)
    else $error("recovery hold wrong");
  smr_wdt_a: assert property (smr_seen && $fell(cpu_rst) |-> watchdog_control_register == 8'h00)
    else $error("watchdog not reset");
  smr_osc_a: assert property (
    smr_seen && $fell(cpu_rst) |-> internal_oscillator_en && internal_oscillator_sel)
    else $error("internal oscillator not chosen");
  vector_fetch_a: assert property (
    pm_rd |-> cpu_rst && (pm_addr == 16'h0002 || pm_addr == 16'h0003))
    else $error("program read outside vector fetch");
  pc_load_a: assert property (pc_load |-> ##[0:2] !cpu_rst)
    else $error("cpu held after pc load");
endmodule // rsr_top_props

//--- verification/test_rsr_top.sv
`timescale 1ns/1ps
`include "rsr_regs.vh"

module test_rsr_top;
  // ==========
  // stimulus and observed signals
  reg clk_sys = 1'b0;
  reg sys_rst = 1'b1;
  reg [11:0] paddr = 12'h000;
  reg psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  reg [31:0] pwdata = 32'h0;
  reg gpio_dir_out = 1'b0, gpio_out = 1'b0, por_event = 1'b0;
  reg supply_brownout_event = 1'b0, watchdog_event = 1'b0, debug_reset_set = 1'b0;
  reg stop_instr = 1'b0, wake_event = 1'b0;
  wire [7:0] pm_rdata;
  wire [31:0] prdata;
  wire pready, pslverr, reset_pin_out, reset_pin_oe, pin_level, debug_reset_pending;
  wire debug_unit_rst, cpu_rst, periph_rst, stop_active, pm_rd, pc_load, irq;
  wire internal_oscillator_en, xtal_en, internal_oscillator_sel;
  wire [15:0] pm_addr, pc_value;
  wire [7:0] watchdog_control_register;
  int failures = 0, n_tests = 0, cyc, low_cnt;
  reg [31:0] q;
  reg e;

  always #20 clk_sys = ~clk_sys;

  // program memory stand-in; answers while the read strobe is high
  assign pm_rdata = !pm_rd ? 8'hee : (pm_addr == 16'h0002) ? 8'h12 :
    (pm_addr == 16'h0003) ? 8'h34 : 8'h5a;

  rsr_top #(.SMR_XTAL_CYCLES(20)) i_rsr_top (.clk_sys, .sys_rst, .paddr, .psel, .penable,
    .pwrite, .pwdata, .prdata, .pready, .pslverr, .reset_pin_n_in(pin_level), .reset_pin_out,
    .reset_pin_oe, .gpio_dir_out, .gpio_out, .por_event, .supply_brownout_event,
    .watchdog_event, .debug_reset_set, .debug_reset_pending, .debug_unit_rst, .stop_instr,
    .wake_event, .cpu_rst, .periph_rst, .stop_active, .pm_addr, .pm_rd, .pm_rdata, .pc_load,
    .pc_value, .internal_oscillator_en, .xtal_en, .internal_oscillator_sel,
    .watchdog_control_register, .irq);

  rsr_pin_partner i_rsr_pin_partner (.clk_sys, .reset_pin_out, .reset_pin_oe, .pin_level);

  // ==========
  // shared tasks
  task automatic check(input [31:0] seen, input [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // one apb transfer; request held until pready is sampled high
  task automatic apb(input bit w, input [11:0] a, input [31:0] d);
    int k = 0;
    @(posedge clk_sys);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do begin
      @(posedge clk_sys);
      k++;
    end while (pready !== 1'b1 && k < 20);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (k >= 20) begin
      failures++;
      print_verdict();
    end
  endtask

  task automatic wr(input [11:0] a, input [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rd(input [11:0] a, input [31:0] exp);
    apb(1'b0, a, 32'h0);
    check(q, exp);
  endtask

  // waits for cpu_rst to reach lvl, counting cycles and low pin cycles
  task automatic wait_rst(input bit lvl);
    cyc = 0;
    if (lvl)
      low_cnt = 0;
    do begin
      @(negedge clk_sys);
      cyc++;
      if (pin_level === 1'b0)
        low_cnt++;
    end while (cpu_rst !== lvl && cyc < 6000);
    if (cyc >= 6000) begin
      failures++;
      print_verdict();
    end
  endtask

  // ==========
  // scenarios
  task automatic t_power();
    wait_rst(1'b1);
    wait_rst(1'b0);
    check(low_cnt >= 16, 32'h1);
    check(pc_value, 16'h1234);
    rd(`RSR_OFS_CAUSE, 32'h1);
    rd(`RSR_OFS_OSC, 32'h5);
    rd(`RSR_OFS_WDT, 32'h0);
    wr(12'h100, 32'hff);
    check(e, 1'b1);
    rd(`RSR_OFS_CTRL, 32'h2);
    wr(`RSR_OFS_CAUSE, 32'h1f);
    wr(`RSR_OFS_IRQ_STAT, 32'h1f);
  endtask

  task automatic t_glitch();
    i_rsr_pin_partner.pull_low(2);
    repeat (10) @(negedge clk_sys);
    check(cpu_rst, 1'b0);
  endtask

  task automatic t_ext();
    i_rsr_pin_partner.pull_low(4);
    wait_rst(1'b1);
    check(cyc <= 6, 32'h1);
    wait_rst(1'b0);
    repeat (8) @(negedge clk_sys);
    fork
      i_rsr_pin_partner.pull_low(40);
    join_none
    repeat (35) @(negedge clk_sys);
    check(cpu_rst, 1'b1);
    wait_rst(1'b0);
    rd(`RSR_OFS_CAUSE, 32'h2);
    wr(`RSR_OFS_CAUSE, 32'h1f);
  endtask

  task automatic t_irq();
    rd(`RSR_OFS_IRQ_STAT, 32'h1);
    wr(`RSR_OFS_IRQ_MASK, 32'h1e);
    repeat (2) @(negedge clk_sys);
    check(irq, 1'b0);
    wr(`RSR_OFS_IRQ_MASK, 32'h1);
    repeat (2) @(negedge clk_sys);
    check(irq, 1'b1);
    wr(`RSR_OFS_IRQ_STAT, 32'h1);
    repeat (2) @(negedge clk_sys);
    check(irq, 1'b0);
  endtask

  // power-on, brown-out, watchdog
  task automatic t_internal();
    for (int i = 0; i < 3; i++) begin
      @(posedge clk_sys);
      {por_event, supply_brownout_event, watchdog_event} <= 3'b100 >> i;
      @(posedge clk_sys);
      {por_event, supply_brownout_event, watchdog_event} <= 3'b000;
      wait_rst(1'b1);
      wait_rst(1'b0);
      check(low_cnt >= 16, 32'h1);
      rd(`RSR_OFS_CAUSE, (i == 0) ? 32'h1 : (i == 1) ? 32'h4 : 32'h8);
      wr(`RSR_OFS_CAUSE, 32'h1f);
    end
  endtask

  task automatic t_debug();
    @(posedge clk_sys);
    debug_reset_set <= 1'b1;
    @(posedge clk_sys);
    debug_reset_set <= 1'b0;
    wait_rst(1'b1);
    check({periph_rst, debug_unit_rst}, 2'b10);
    wait_rst(1'b0);
    check(debug_reset_pending, 1'b0);
    check(low_cnt >= 16, 32'h1);
    rd(`RSR_OFS_CAUSE, 32'h1);
  endtask

  task automatic t_alt();
    wr(`RSR_OFS_CTRL, 32'h0);
    gpio_dir_out <= 1'b1;
    gpio_out <= 1'b1;
    repeat (2) @(negedge clk_sys);
    check({reset_pin_oe, reset_pin_out}, 2'b11);
    @(posedge clk_sys);
    gpio_out <= 1'b0;
    repeat (10) @(negedge clk_sys);
    check({reset_pin_oe, reset_pin_out, cpu_rst}, 3'b100);
    @(posedge clk_sys);
    gpio_dir_out <= 1'b0;
    wr(`RSR_OFS_CTRL, 32'h2);
    repeat (2) @(negedge clk_sys);
    check({reset_pin_oe, cpu_rst}, 2'b00);
  endtask

  // crystal off, then on
  task automatic t_stop();
    for (int i = 0; i < 2; i++) begin
      wr(`RSR_OFS_WDT, 32'h5a);
      repeat (4) @(negedge clk_sys);
      check(stop_active, 1'b0);
      @(posedge clk_sys);
      stop_instr <= 1'b1;
      @(posedge clk_sys);
      stop_instr <= 1'b0;
      repeat (2) @(negedge clk_sys);
      check(stop_active, 1'b1);
      @(posedge clk_sys);
      wake_event <= 1'b1;
      @(posedge clk_sys);
      wake_event <= 1'b0;
      wait_rst(1'b1);
      wait_rst(1'b0);
      check(cyc >= (i ? 20 : 66) && cyc <= (i ? 32 : 78), 32'h1);
      check(pc_value, 16'h1234);
      rd(`RSR_OFS_OSC, i ? 32'h7 : 32'h5);
      rd(`RSR_OFS_WDT, 32'h0);
      rd(`RSR_OFS_CTRL, 32'h2);
      wr(`RSR_OFS_OSC, 32'h2);
    end
  endtask

  initial begin
    repeat (5) @(posedge clk_sys);
    sys_rst <= 1'b0;
    t_power();
    t_glitch();
    t_ext();
    t_irq();
    t_internal();
    t_debug();
    t_alt();
    t_stop();
    print_verdict();
  end
endmodule // test_rsr_top

bind rsr_top rsr_top_props #(.SMR_IPO_CYCLES(SMR_IPO_CYCLES), .SMR_XTAL_CYCLES(SMR_XTAL_CYCLES))
  i_rsr_top_props (.clk_sys, .sys_rst, .reset_pin_n_in, .reset_pin_out, .reset_pin_oe,
  .por_event, .supply_brownout_event, .watchdog_event, .debug_reset_pending, .debug_unit_rst,
  .stop_instr, .wake_event, .cpu_rst, .periph_rst, .stop_active, .pm_addr, .pm_rd, .pc_load,
  .internal_oscillator_en, .internal_oscillator_sel, .xtal_en, .watchdog_control_register);
